/* rtl/rst_seq_map.vh */
// constants for the reset sequencer: offsets, reset values, timing counts
`ifndef RST_SEQ_MAP_VH
`define RST_SEQ_MAP_VH
// apb register byte offsets
`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_IRQ_STAT 12'h008
`define OFF_IRQ_MASK 12'h00c
`define OFF_INT_CTRL 12'h010
`define OFF_TIMER_CTRL 12'h014
`define OFF_CONV_CTRL 12'h018
`define OFF_CONV_CLK 12'h01c
`define OFF_PORTA 12'h020
`define OFF_PORTA_DIR 12'h024
`define OFF_PORTB 12'h028
`define OFF_PORTB_DIR 12'h02c
`define OFF_PORTD 12'h030
`define OFF_PORTD_DIR 12'h034
`define OFF_PC 12'h038
// ctrl bits (write one = pulse)
`define CTRL_SLEEP 0
`define CTRL_WAKE 1
`define CTRL_CLRWDT 2
// status bits
`define ST_TIMEOUT 0
`define ST_POWERDOWN 1
`define ST_RUN 2
`define ST_SLEEP 3
// event bits in irq status
`define EV_POR 0
`define EV_PIN 1
`define EV_PIN_WAKE 2
`define EV_WDT 3
`define EV_WARM 4
`define EV_RUN 5
`define EV_W 6
// reset values
`define RV_INT_CTRL 8'h00
`define RV_TIMER_CTRL 8'h08
`define RV_CONV_CTRL 8'h40
`define RV_CONV_CLK 3'h4
`define RV_PORT 8'hff
`define RV_PORT4 4'hf
`define RV_PORT1 1'h1
`define RV_PC 11'h000
`define RV_STACK 3'h0
// timing
`define STARTUP_CYCLES 1024
`define OPT_CYCLES 16
`define STARTUP_LOAD 11'd1023
`define OPT_LOAD 11'd16
`define CNT_W 11
`endif

/* rtl/delay_counter.v */
// down counter that raises done after a loaded number of cycles
`timescale 1ns/1ns
module delay_counter (
  input wire pclk,
  input wire presetn,
  input wire start,
  input wire [10:0] load,
  output wire done
);
  reg [10:0] cnt_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cnt_reg <= 11'h000;
    else if (start)
      cnt_reg <= load;
    else if (cnt_reg != 11'h000)
      cnt_reg <= cnt_reg - 11'h001;
  end
  assign done = (cnt_reg == 11'h000);
endmodule // delay_counter

/* rtl/reg_bank.v */
// resettable register with cold-reset load and software write
`timescale 1ns/1ns
module reg_bank #(
  parameter W = 8,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire pclk,
  input wire presetn,
  input wire cold_load,
  input wire wr_en,
  input wire [W-1:0] wr_data,
  output reg [W-1:0] q
);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      q <= INIT;
    else if (cold_load)
      q <= INIT;
    else if (wr_en)
      q <= wr_data;
  end
endmodule // reg_bank

/* rtl/mcu_reset_sequencer.v */
// reset and start-up sequencer with apb status and control registers
`timescale 1ns/1ns
`include "rst_seq_map.vh"
module mcu_reset_sequencer (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire ext_reset_pin_n,
  input wire wdt_timeout,
  output wire core_reset_n,
  output wire pc_reset,
  output wire sp_reset,
  output wire wdt_clear,
  output wire cold_reset,
  output wire irq
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [2:0] S_OPT = 3'd0;
  localparam [2:0] S_SST = 3'd1;
  localparam [2:0] S_RUN = 3'd2;
  localparam [2:0] S_SLEEP = 3'd3;
  localparam [2:0] S_WAKE = 3'd4;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg timeout_flag;
  reg powerdown_flag;
  reg pin_q_reg;
  reg [6:0] irq_stat_reg;
  reg [6:0] irq_mask_reg;
  reg [10:0] pc_reg;
  reg [2:0] stack_pointer;
  reg first_reg;
  wire wr = psel && penable && pwrite;
  wire start_cnt;
  wire [10:0] cnt_load;
  wire cnt_done;
  // ----------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------
  wire pin_low = !ext_reset_pin_n;
  wire pin_fall = pin_low && !pin_q_reg;
  wire in_run = (state_reg == S_RUN);
  wire in_sleep = (state_reg == S_SLEEP);
  wire ev_pin = pin_fall && !in_sleep;
  wire ev_pin_wake = pin_fall && in_sleep;
  wire ev_wdt = wdt_timeout && in_run;
  wire ev_warm = wdt_timeout && in_sleep;
  wire ctrl_wr = wr && (paddr == `OFF_CTRL);
  wire sw_sleep = ctrl_wr && pwdata[`CTRL_SLEEP] && in_run;
  wire sw_wake = ctrl_wr && pwdata[`CTRL_WAKE] && in_sleep;
  wire sw_clrwdt = ctrl_wr && pwdata[`CTRL_CLRWDT] && in_run;
  wire full_rst = ev_pin || ev_pin_wake || ev_wdt;
  wire any_wake = sw_wake || ev_warm;
  assign cold_reset = full_rst || first_reg;
  function [31:0] z8;
    input [7:0] v;
    z8 = {24'h000000, v};
  endfunction
  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  assign start_cnt = cold_reset || any_wake ||
    (state_reg == S_OPT && cnt_done);
  assign cnt_load = (cold_reset) ? `OPT_LOAD :
    `STARTUP_LOAD;
  delay_counter u_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .start(start_cnt),
    .load(cnt_load),
    .done(cnt_done)
  );
  always @* begin
    state_next = state_reg;
    if (cold_reset)
      state_next = S_OPT;
    else if (any_wake)
      state_next = S_WAKE;
    else begin
      case (state_reg)
        S_OPT: if (cnt_done) state_next = S_SST;
        S_SST: if (cnt_done) state_next = S_RUN;
        S_WAKE: if (cnt_done) state_next = S_RUN;
        S_RUN: if (sw_sleep) state_next = S_SLEEP;
        S_SLEEP: state_next = S_SLEEP;
        default: state_next = S_OPT;
      endcase
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_OPT;
      first_reg <= 1'b1;
      pin_q_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      first_reg <= 1'b0;
      pin_q_reg <= pin_low;
    end
  end
  // core held in reset through option and start-up delays
  assign core_reset_n = (state_reg == S_RUN) ||
    (state_reg == S_SLEEP);
  assign pc_reset = cold_reset || ev_warm;
  assign sp_reset = pc_reset;
  assign wdt_clear = cold_reset || pin_low || sw_clrwdt ||
    sw_sleep || !core_reset_n;
  // ----------------------------------------------------------------
  // flags and visible core state
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_flag <= 1'b0;
      powerdown_flag <= 1'b0;
      pc_reg <= `RV_PC;
      stack_pointer <= `RV_STACK;
    end else begin
      if (ev_pin_wake) begin
        timeout_flag <= 1'b0;
        powerdown_flag <= 1'b1;
      end else if (ev_wdt) begin
        timeout_flag <= 1'b1;
      end else if (ev_warm) begin
        timeout_flag <= 1'b1;
        powerdown_flag <= 1'b1;
      end else if (sw_sleep) begin
        timeout_flag <= 1'b0;
        powerdown_flag <= 1'b1;
      end else if (sw_clrwdt) begin
        timeout_flag <= 1'b0;
        powerdown_flag <= 1'b0;
      end
      if (pc_reset) begin
        pc_reg <= `RV_PC;
        stack_pointer <= `RV_STACK;
      end else if (wr && paddr == `OFF_PC && in_run)
        pc_reg <= pwdata[10:0];
    end
  end
  // ----------------------------------------------------------------
  // controlled registers, loaded only on cold resets
  // ----------------------------------------------------------------
  wire [7:0] interrupt_control_reg;
  wire [7:0] timer_control_reg;
  wire [7:0] converter_control_reg;
  wire [2:0] converter_clock_reg;
  wire [7:0] port_a_data;
  wire [7:0] port_a_direction;
  wire [3:0] port_b_data;
  wire [3:0] port_b_direction;
  wire port_d_data;
  wire port_d_direction;
  // warm reset leaves these untouched (cold_load excludes it)
  reg_bank #(.W(8), .INIT(`RV_INT_CTRL)) u_int_ctrl (
    .pclk(pclk),
    .presetn(presetn),
    .cold_load(cold_reset),
    .wr_en(wr && paddr == `OFF_INT_CTRL),
    .wr_data({1'b0, pwdata[6:0]}),
    .q(interrupt_control_reg)
  );
  reg_bank #(.W(8), .INIT(`RV_TIMER_CTRL)) u_timer_ctrl (
    .pclk(pclk),
    .presetn(presetn),
    .cold_load(cold_reset),
    .wr_en(wr && paddr == `OFF_TIMER_CTRL),
    .wr_data({pwdata[7:6], 1'b0, pwdata[4:0]}),
    .q(timer_control_reg)
  );
  reg_bank #(.W(8), .INIT(`RV_CONV_CTRL)) u_conv_ctrl (
    .pclk(pclk),
    .presetn(presetn),
    .cold_load(cold_reset),
    .wr_en(wr && paddr == `OFF_CONV_CTRL),
    .wr_data(pwdata[7:0]),
    .q(converter_control_reg)
  );
  reg_bank #(.W(3), .INIT(`RV_CONV_CLK)) u_conv_clk (
    .pclk(pclk),
    .presetn(presetn),
    .cold_load(cold_reset),
    .wr_en(wr && paddr == `OFF_CONV_CLK),
    .wr_data(pwdata[2:0]),
    .q(converter_clock_reg)
  );
  reg_bank #(.W(8), .INIT(`RV_PORT)) u_porta (
    .pclk(pclk),
    .presetn(presetn),
    .cold_load(cold_reset),
    .wr_en(wr && paddr == `OFF_PORTA),
    .wr_data(pwdata[7:0]),
    .q(port_a_data)
  );
  reg_bank #(.W(8), .INIT(`RV_PORT)) u_porta_dir (
    .pclk(pclk),
    .presetn(presetn),
    .cold_load(cold_reset),
    .wr_en(wr && paddr == `OFF_PORTA_DIR),
    .wr_data(pwdata[7:0]),
    .q(port_a_direction)
  );
  reg_bank #(.W(4), .INIT(`RV_PORT4)) u_portb (
    .pclk(pclk),
    .presetn(presetn),
    .cold_load(cold_reset),
    .wr_en(wr && paddr == `OFF_PORTB),
    .wr_data(pwdata[3:0]),
    .q(port_b_data)
  );
  reg_bank #(.W(4), .INIT(`RV_PORT4)) u_portb_dir (
    .pclk(pclk),
    .presetn(presetn),
    .cold_load(cold_reset),
    .wr_en(wr && paddr == `OFF_PORTB_DIR),
    .wr_data(pwdata[3:0]),
    .q(port_b_direction)
  );
  reg_bank #(.W(1), .INIT(`RV_PORT1)) u_portd (
    .pclk(pclk),
    .presetn(presetn),
    .cold_load(cold_reset),
    .wr_en(wr && paddr == `OFF_PORTD),
    .wr_data(pwdata[0]),
    .q(port_d_data)
  );
  reg_bank #(.W(1), .INIT(`RV_PORT1)) u_portd_dir (
    .pclk(pclk),
    .presetn(presetn),
    .cold_load(cold_reset),
    .wr_en(wr && paddr == `OFF_PORTD_DIR),
    .wr_data(pwdata[0]),
    .q(port_d_direction)
  );
  // scratch, count and result registers sit in the core and are not
  // touched here, so they keep or lose contents as the core dictates
  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  wire [6:0] ev_vec = {ev_warm, (state_next == S_RUN && !in_run),
    ev_warm, ev_wdt, ev_pin_wake, ev_pin, first_reg};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= 7'h00;
      irq_mask_reg <= 7'h00;
    end else begin
      // a new event wins over a clear in the same cycle
      irq_stat_reg <= (irq_stat_reg & ~((wr && paddr == `OFF_IRQ_STAT)
        ? pwdata[6:0] : 7'h00)) | ev_vec;
      if (wr && paddr == `OFF_IRQ_MASK)
        irq_mask_reg <= pwdata[6:0];
    end
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);
  // ----------------------------------------------------------------
  // apb read
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  always @* begin
    case (paddr)
      `OFF_STATUS: prdata = {28'h0000000, in_sleep, core_reset_n,
        powerdown_flag, timeout_flag};
      `OFF_IRQ_STAT: prdata = {25'h0000000, irq_stat_reg};
      `OFF_IRQ_MASK: prdata = {25'h0000000, irq_mask_reg};
      `OFF_INT_CTRL: prdata = z8(interrupt_control_reg);
      `OFF_TIMER_CTRL: prdata = z8(timer_control_reg);
      `OFF_CONV_CTRL: prdata = z8(converter_control_reg);
      `OFF_CONV_CLK: prdata = {29'h00000000, converter_clock_reg};
      `OFF_PORTA: prdata = z8(port_a_data);
      `OFF_PORTA_DIR: prdata = z8(port_a_direction);
      `OFF_PORTB: prdata = {28'h0000000, port_b_data};
      `OFF_PORTB_DIR: prdata = {28'h0000000, port_b_direction};
      `OFF_PORTD: prdata = {31'h00000000, port_d_data};
      `OFF_PORTD_DIR: prdata = {31'h00000000, port_d_direction};
      `OFF_PC: prdata = {18'h00000, stack_pointer, pc_reg};
      default: prdata = 32'h00000000;
    endcase
  end
endmodule // mcu_reset_sequencer

/* dv/rst_seq_properties.sv */
// port checker for the reset sequencer
`timescale 1ns/1ns
module rst_seq_checker (
  input wire pclk,
  input wire presetn,
  input wire ext_reset_pin_n,
  input wire wdt_timeout,
  input wire core_reset_n,
  input wire pc_reset,
  input wire sp_reset,
  input wire wdt_clear,
  input wire cold_reset
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // -------------------------------------------
  // length of the current core hold
  // -------------------------------------------
  logic [11:0] low_cnt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      low_cnt <= 12'h000;
    else if (core_reset_n)
      low_cnt <= 12'h000;
    else if (low_cnt != 12'hfff)
      low_cnt <= low_cnt + 12'h001;
  end
  sequence s_pin_fall;
    core_reset_n && $fell(ext_reset_pin_n);
  endsequence
  sequence s_wdt_hit;
    core_reset_n && wdt_timeout;
  endsequence
  property p_pin_wdt; !ext_reset_pin_n |-> wdt_clear; endproperty
  a_pin_wdt: assert property (p_pin_wdt)
    else $error("pin low without watchdog clear");
  property p_hold_wdt; !core_reset_n |-> wdt_clear; endproperty
  a_hold_wdt: assert property (p_hold_wdt)
    else $error("core held but watchdog not cleared");
  property p_pc_sp; pc_reset |-> sp_reset; endproperty
  a_pc_sp: assert property (p_pc_sp)
    else $error("program counter reset without stack reset");
  property p_cold_fx; cold_reset |-> pc_reset && wdt_clear; endproperty
  a_cold_fx: assert property (p_cold_fx)
    else $error("cold reset missing its effects");
  property p_startup;
    $rose(core_reset_n) |-> low_cnt >= 12'd1024;
  endproperty
  a_startup: assert property (p_startup)
    else $error("core released before start-up delay");
  property p_pin_rst; s_pin_fall |-> ##[0:3] !core_reset_n; endproperty
  a_pin_rst: assert property (p_pin_rst)
    else $error("pin fall did not reset core");
  property p_wdt_rst; s_wdt_hit |-> ##[0:3] !core_reset_n; endproperty
  a_wdt_rst: assert property (p_wdt_rst)
    else $error("watchdog time-out did not reset core");
  property p_wdt_pc; s_wdt_hit |-> ##[0:3] pc_reset; endproperty
  a_wdt_pc: assert property (p_wdt_pc)
    else $error("watchdog time-out did not reset program counter");
  property p_cold_pulse; cold_reset |=> !cold_reset; endproperty
  a_cold_pulse: assert property (p_cold_pulse)
    else $error("cold reset longer than one cycle");
endmodule // rst_seq_checker
bind mcu_reset_sequencer rst_seq_checker i_rst_seq_checker (
  .pclk(pclk), .presetn(presetn), .ext_reset_pin_n(ext_reset_pin_n),
  .wdt_timeout(wdt_timeout), .core_reset_n(core_reset_n),
  .pc_reset(pc_reset), .sp_reset(sp_reset), .wdt_clear(wdt_clear),
  .cold_reset(cold_reset));

/* dv/reset_source_model.sv */
// model of the reset pin circuit and the watchdog time-out source
`timescale 1ns/1ns
module reset_source_model (
  input wire pclk,
  output logic ext_reset_pin_n,
  output logic wdt_timeout
);
  initial begin
    ext_reset_pin_n = 1'b1;
    wdt_timeout = 1'b0;
  end
  // pull the pin low for two clocks
  task pin_reset();
    @(posedge pclk);
    ext_reset_pin_n <= 1'b0;
    repeat (2) @(posedge pclk);
    ext_reset_pin_n <= 1'b1;
  endtask
  task wdt_overflow();
    @(posedge pclk);
    wdt_timeout <= 1'b1;
    @(posedge pclk);
    wdt_timeout <= 1'b0;
  endtask
endmodule // reset_source_model

/* dv/testbench.sv */
// self-checking bench for the reset sequencer
`timescale 1ns/1ns
`include "rst_seq_map.vh"
module testbench;
  logic pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire pready, pslverr, ext_reset_pin_n, wdt_timeout, core_reset_n, irq;
  int bad_count = 0;
  int comparisons = 0;
  int n;
  localparam int SPLIT = `STARTUP_CYCLES + `OPT_CYCLES - 8;
  logic [11:0] ra [10] = '{12'h010, 12'h014, 12'h018, 12'h01c, 12'h020,
    12'h024, 12'h028, 12'h02c, 12'h030, 12'h034};
  logic [31:0] rv [10] = '{32'h00, 32'h08, 32'h40, 32'h04, 32'hff,
    32'hff, 32'h0f, 32'h0f, 32'h01, 32'h01};
  mcu_reset_sequencer i_mcu_reset_sequencer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .ext_reset_pin_n(ext_reset_pin_n),
    .wdt_timeout(wdt_timeout), .core_reset_n(core_reset_n), .pc_reset(),
    .sp_reset(), .wdt_clear(), .cold_reset(), .irq(irq));
  reset_source_model i_reset_source_model (.pclk(pclk),
    .ext_reset_pin_n(ext_reset_pin_n), .wdt_timeout(wdt_timeout));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // -------------------------------------------
  // shared tasks
  // -------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_run();
    while (core_reset_n === 1'b1) @(posedge pclk);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (core_reset_n !== 1'b1);
  endtask
  task end_of_test();
    $display("counts: %0d compared, %0d mismatched", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // -------------------------------------------
  // scenarios
  // -------------------------------------------
  task t_power_up();
    wait_run();
    chk({31'h0, n > SPLIT}, 32'h1);
    apb(1'b0, `OFF_STATUS, 32'h0);
    chk(rd & 32'h3, 32'h0);
    chk({31'h0, pslverr}, 32'h0);
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd & 32'hff, rv[i]);
    end
    apb(1'b0, 12'h03c, 32'h0);
    chk(rd, 32'h0);
    $display("test power_up done");
  endtask
  task t_irq();
    apb(1'b1, `OFF_IRQ_MASK, 32'h0);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `OFF_IRQ_MASK, 32'h1);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `OFF_IRQ_STAT, 32'h1);
    @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    $display("test irq done");
  endtask
  task t_wdt_run();
    apb(1'b1, `OFF_TIMER_CTRL, 32'h33);
    i_reset_source_model.wdt_overflow();
    wait_run();
    chk({31'h0, n > SPLIT}, 32'h1);
    apb(1'b0, `OFF_STATUS, 32'h0);
    chk(rd & 32'h3, 32'h1);
    apb(1'b0, `OFF_TIMER_CTRL, 32'h0);
    chk(rd & 32'hff, 32'h08);
    $display("test wdt_run done");
  endtask
  task t_pin_run();
    apb(1'b1, `OFF_PORTA, 32'h12);
    i_reset_source_model.pin_reset();
    wait_run();
    chk({31'h0, n > SPLIT}, 32'h1);
    apb(1'b0, `OFF_STATUS, 32'h0);
    chk(rd & 32'h3, 32'h1);
    apb(1'b0, `OFF_PORTA, 32'h0);
    chk(rd & 32'hff, 32'hff);
    $display("test pin_run done");
  endtask
  task t_sleep_pin();
    apb(1'b1, `OFF_CTRL, 32'h4);
    apb(1'b0, `OFF_STATUS, 32'h0);
    chk(rd & 32'h3, 32'h0);
    apb(1'b1, `OFF_CTRL, 32'h1);
    apb(1'b0, `OFF_STATUS, 32'h0);
    chk(rd & 32'h3, 32'h2);
    i_reset_source_model.pin_reset();
    wait_run();
    chk({31'h0, n > `STARTUP_CYCLES - 8}, 32'h1);
    apb(1'b0, `OFF_STATUS, 32'h0);
    chk(rd & 32'h3, 32'h2);
    $display("test sleep_pin done");
  endtask
  task t_warm();
    apb(1'b1, `OFF_PORTA, 32'h5a);
    apb(1'b1, `OFF_INT_CTRL, 32'h05);
    apb(1'b1, `OFF_CTRL, 32'h1);
    i_reset_source_model.wdt_overflow();
    wait_run();
    chk({31'h0, n < SPLIT}, 32'h1);
    chk({31'h0, n > `STARTUP_CYCLES - 8}, 32'h1);
    apb(1'b0, `OFF_STATUS, 32'h0);
    chk(rd & 32'h3, 32'h3);
    apb(1'b0, `OFF_PORTA, 32'h0);
    chk(rd & 32'hff, 32'h5a);
    apb(1'b0, `OFF_INT_CTRL, 32'h0);
    chk(rd & 32'hff, 32'h05);
    // software wake from sleep: start-up delay only, flags kept
    apb(1'b1, `OFF_CTRL, 32'h1);
    apb(1'b1, `OFF_CTRL, 32'h2);
    wait_run();
    chk({31'h0, n > `STARTUP_CYCLES - 8}, 32'h1);
    chk({31'h0, n < SPLIT}, 32'h1);
    apb(1'b0, `OFF_STATUS, 32'h0);
    chk(rd & 32'h3, 32'h2);
    $display("test warm done");
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_power_up();
    t_irq();
    t_wdt_run();
    t_pin_run();
    t_sleep_pin();
    t_warm();
    end_of_test();
  end
  initial begin
    #(40 * 20000);
    bad_count++;
    end_of_test();
  end
endmodule // testbench
